// >>> test/scd_mem_model.sv
// Host memory model that takes the dump engine's word writes.
`timescale 1ns/1ps
`default_nettype none
module scd_mem_model (
    input wire logic clock,
    input wire logic resetn,
    input wire logic slow,
    input wire logic mem_valid,
    input wire logic [63:0] mem_addr,
    input wire logic [63:0] mem_wdata,
    output logic mem_ready
);
    logic [63:0] word_reg [8];
    logic [57:0] base_reg;
    logic [2:0] idx_reg;
    logic stall_reg;
    int writes;
    int order_err;
    // In slow mode every other cycle refuses the word.
    assign mem_ready = !(slow && stall_reg);
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            stall_reg <= 1'b0;
            idx_reg <= 3'h0;
            writes <= 0;
            order_err <= 0;
        end else begin
            stall_reg <= !stall_reg;
            if (mem_valid && mem_ready) begin
                word_reg[mem_addr[5:3]] <= mem_wdata;
                base_reg <= mem_addr[63:6];
                if (mem_addr[5:0] != {idx_reg, 3'h0}) begin
                    order_err <= order_err + 1;
                end
                idx_reg <= idx_reg + 3'h1;
                writes <= writes + 1;
            end
        end
    end
endmodule : scd_mem_model
`default_nettype wire

// >>> test/test_stats_counter_dump.sv
// Self-checking bench for the statistics dump engine.
`timescale 1ns/1ps
`default_nettype none
module test_stats_counter_dump;
    logic clock, resetn, psel, penable, pwrite, slow;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, mem_valid, mem_ready, err;
    logic [63:0] mem_addr, mem_wdata;
    logic [16:0] ev;
    logic [63:0] exp_w [8];
    int miscompares = 0;
    int cmp_count = 0;
    int dumps = 0;

    scd_top u_dut (.clock(clock), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ev_tx_ok(ev[0]), .ev_rx_ok(ev[1]),
        .ev_tx_abort(ev[2]), .ev_carrier_lost(ev[3]),
        .ev_tx_underrun(ev[4]), .ev_late_collision(ev[5]),
        .ev_rx_crc_error(ev[6]), .ev_fifo_full_drop(ev[7]),
        .ev_align_error(ev[8]), .ev_single_collision(ev[9]),
        .ev_multi_collision(ev[10]), .ev_rx_unicast_match(ev[11]),
        .ev_rx_broadcast(ev[12]), .ev_rx_group_addr(ev[13]),
        .ev_tx_underrun_drop(ev[14]), .rx_len_over8(ev[15]),
        .mii_mode(ev[16]), .mem_valid(mem_valid),
        .mem_ready(mem_ready), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata));
    scd_mem_model u_mem (.clock(clock), .resetn(resetn), .slow(slow),
        .mem_valid(mem_valid), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_ready(mem_ready));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb

    task automatic fire(input logic [16:0] m, input int n);
        ev <= m;
        repeat (n) @(posedge clock);
        ev <= '0;
        @(posedge clock);
    endtask : fire

    // Starts a dump, optionally pokes the register mid-run, then polls.
    task automatic dump(input logic [63:0] base, input bit poke);
        int n;
        apb(12'h014, 1'b1, base[63:32]);
        apb(12'h010, 1'b1, {base[31:6], 6'h08});
        if (poke) begin
            apb(12'h010, 1'b1, 32'h0000_0f48);
            apb(12'h010, 1'b0, 32'h0);
            check({63'h0, rd[3]}, 64'h1);
            apb(12'h014, 1'b1, 32'h0);
        end
        n = 0;
        do begin
            apb(12'h010, 1'b0, 32'h0);
            n++;
        end while (rd[3] === 1'b1 && n < 60);
        dumps++;
        check({32'h0, rd}, {32'h0, base[31:6], 6'h00});
        for (int i = 0; i < 8; i++) begin
            check(u_mem.word_reg[i], exp_w[i]);
        end
        check({6'h0, u_mem.base_reg}, {6'h0, base[63:6]});
        check(64'(u_mem.writes), 64'(8 * dumps));
        check(64'(u_mem.order_err), 64'h0);
        if (poke) begin
            apb(12'h014, 1'b0, 32'h0);
            check({32'h0, rd}, {32'h0, base[63:32]});
        end
    endtask : dump

    task automatic t_regs();
        apb(12'h010, 1'b0, 32'h0);
        check({31'h0, err, rd}, 64'h0);
        apb(12'h014, 1'b1, 32'hdead_beef);
        apb(12'h014, 1'b0, 32'h0);
        check({32'h0, rd}, 64'hdead_beef);
        apb(12'h010, 1'b1, 32'hffff_fff7);
        apb(12'h010, 1'b0, 32'h0);
        check({32'h0, rd}, 64'hffff_ffc0);
        apb(12'h020, 1'b0, 32'h0);
        check({31'h0, err, rd}, 64'h1_0000_0000);
    endtask : t_regs

    // Each event gets a distinct count so swapped fields show up.
    task automatic t_counts();
        logic [16:0] m;
        for (int i = 0; i < 15; i++) begin
            m = 17'h1 << i;
            m[15] = (i == 6);
            m[16] = (i == 8);
            fire(m, i + 1);
        end
        fire(17'h00040, 2);
        fire(17'h00100, 2);
        fire(17'h18000, 3);
        exp_w = '{64'd1, 64'd2, 64'd18, {16'd9, 16'd8, 32'd15},
            {32'd11, 32'd10}, 64'd12, 64'd13, {16'd15, 16'd3, 32'd14}};
        dump(64'h0000_0000_0000_0040, 1'b0);
    endtask : t_counts

    // Stalling memory, upper base, restart attempt, counts kept.
    task automatic t_stall();
        slow <= 1'b1;
        fire(17'h00001, 1);
        exp_w[0] = 64'd2;
        dump(64'h1234_5678_9abc_de40, 1'b1);
        slow <= 1'b0;
    endtask : t_stall

    task automatic give_verdict();
        $display("Compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        slow = 1'b0;
        ev = '0;
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        t_regs();
        t_counts();
        t_stall();
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        give_verdict();
    end
endmodule : test_stats_counter_dump
`default_nettype wire

// >>> verilog/scd_counter.sv
// Wrapping event counter of configurable width.
`timescale 1ns/1ps
`default_nettype none
module scd_counter #(
    parameter int W = 64
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic inc,
    output logic [W-1:0] count
);
    logic [W-1:0] count_reg;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            count_reg <= '0;
        end else if (inc) begin
            count_reg <= count_reg + 1'b1;
        end
    end

    assign count = count_reg;
endmodule : scd_counter
`default_nettype wire

// >>> verilog/scd_fifo.sv
// Flip-flop FIFO between the dump sequencer and the memory write port.
`timescale 1ns/1ps
`default_nettype none
module scd_fifo #(
    parameter int W = 67,
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic resetn,
    scd_stream_if.snk in_if,
    scd_stream_if.src out_if
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    logic [W-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    wire push = in_if.valid && in_if.ready;
    wire pop = out_if.valid && out_if.ready;

    assign in_if.ready = (cnt_reg != FULL);
    assign out_if.valid = (cnt_reg != '0);
    assign out_if.data = mem_reg[rd_reg];

    // Depth must be a power of two so that the pointers wrap by themselves.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) wr_reg <= wr_reg + 1'b1;
            if (pop) rd_reg <= rd_reg + 1'b1;
            if (push && !pop) cnt_reg <= cnt_reg + 1'b1;
            else if (pop && !push) cnt_reg <= cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (push) mem_reg[wr_reg] <= in_if.data;
    end
endmodule : scd_fifo
`default_nettype wire

// >>> verilog/scd_params.svh
// Offsets, field positions, widths and reset values of the dump engine.
`ifndef SCD_PARAMS_SVH
`define SCD_PARAMS_SVH
`define SCD_ADDR_W 12
`define SCD_DUMP_LO_OFF 12'h010
`define SCD_DUMP_HI_OFF 12'h014
`define SCD_CMD_BIT 3
`define SCD_BASE_LSB 6
`define SCD_BASE_W 58
`define SCD_IDX_W 3
`define SCD_LAST_IDX 3'h7
`define SCD_WORDS 8
`define SCD_BYTE_LSB 3'h0
`define SCD_CNT64_W 64
`define SCD_CNT32_W 32
`define SCD_CNT16_W 16
`define SCD_BASE_RST 58'h0
`define SCD_ZERO32 32'h0
`endif

// >>> verilog/scd_pkg.sv
// Types shared by the statistics dump engine.
`default_nettype none
package scd_pkg;
    typedef enum logic [1:0] {
        SCD_IDLE,
        SCD_FILL,
        SCD_DRAIN
    } scd_state_e;
    typedef logic [63:0] scd_word_t;
endpackage : scd_pkg
`default_nettype wire

// >>> verilog/scd_stream_if.sv
// Valid/ready stream carrying dump words between the engine's modules.
`timescale 1ns/1ps
`default_nettype none
interface scd_stream_if #(parameter int W = 67);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : scd_stream_if
`default_nettype wire

// >>> verilog/scd_top.sv
// Statistics counters and the engine that dumps them into host memory.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "scd_params.svh"
module scd_top
    import scd_pkg::*;
#(
    parameter int FIFO_DEPTH = `SCD_WORDS
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`SCD_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ev_tx_ok,
    input wire logic ev_rx_ok,
    input wire logic ev_tx_abort,
    input wire logic ev_carrier_lost,
    input wire logic ev_tx_underrun,
    input wire logic ev_late_collision,
    input wire logic ev_rx_crc_error,
    input wire logic rx_len_over8,
    input wire logic ev_fifo_full_drop,
    input wire logic ev_align_error,
    input wire logic mii_mode,
    input wire logic ev_single_collision,
    input wire logic ev_multi_collision,
    input wire logic ev_rx_unicast_match,
    input wire logic ev_rx_broadcast,
    input wire logic ev_rx_group_addr,
    input wire logic ev_tx_underrun_drop,
    output logic mem_valid,
    input wire logic mem_ready,
    output logic [63:0] mem_addr,
    output logic [63:0] mem_wdata
);
    localparam int FW = `SCD_IDX_W + 64;

    scd_state_e state_reg;
    scd_state_e state_next;
    logic cmd_reg;
    logic [`SCD_BASE_W-1:0] base_reg;
    logic [`SCD_IDX_W-1:0] idx_reg;
    logic [31:0] prdata_reg;

    logic [63:0] tx_good_count;
    logic [63:0] rx_good_count;
    logic [63:0] tx_fail_count;
    logic [31:0] rx_fail_count;
    logic [15:0] fifo_full_drop_count;
    logic [15:0] align_error_count;
    logic [31:0] single_collision_count;
    logic [31:0] multi_collision_count;
    logic [63:0] rx_unicast_match_count;
    logic [63:0] rx_broadcast_count;
    logic [31:0] rx_group_addr_count;
    logic [15:0] tx_abort_count;
    logic [15:0] tx_underrun_drop_count;

    scd_stream_if #(.W(FW)) fill_if ();
    scd_stream_if #(.W(FW)) mem_if ();

    // Event qualification feeding the counters.
    wire tx_fail_inc = ev_tx_abort || ev_carrier_lost || ev_tx_underrun
        || ev_late_collision;
    wire rx_fail_inc = (ev_rx_crc_error && rx_len_over8) || ev_fifo_full_drop;
    wire align_inc = ev_align_error && mii_mode;

    scd_counter #(.W(`SCD_CNT64_W)) u_tx_good (.clock(clock), .resetn(resetn),
        .inc(ev_tx_ok), .count(tx_good_count));
    scd_counter #(.W(`SCD_CNT64_W)) u_rx_good (.clock(clock), .resetn(resetn),
        .inc(ev_rx_ok), .count(rx_good_count));
    scd_counter #(.W(`SCD_CNT64_W)) u_tx_fail (.clock(clock), .resetn(resetn),
        .inc(tx_fail_inc), .count(tx_fail_count));
    scd_counter #(.W(`SCD_CNT32_W)) u_rx_fail (.clock(clock), .resetn(resetn),
        .inc(rx_fail_inc), .count(rx_fail_count));
    scd_counter #(.W(`SCD_CNT16_W)) u_drop (.clock(clock), .resetn(resetn),
        .inc(ev_fifo_full_drop), .count(fifo_full_drop_count));
    scd_counter #(.W(`SCD_CNT16_W)) u_align (.clock(clock), .resetn(resetn),
        .inc(align_inc), .count(align_error_count));
    scd_counter #(.W(`SCD_CNT32_W)) u_col1 (.clock(clock), .resetn(resetn),
        .inc(ev_single_collision), .count(single_collision_count));
    scd_counter #(.W(`SCD_CNT32_W)) u_colm (.clock(clock), .resetn(resetn),
        .inc(ev_multi_collision), .count(multi_collision_count));
    scd_counter #(.W(`SCD_CNT64_W)) u_ucast (.clock(clock), .resetn(resetn),
        .inc(ev_rx_unicast_match), .count(rx_unicast_match_count));
    scd_counter #(.W(`SCD_CNT64_W)) u_bcast (.clock(clock), .resetn(resetn),
        .inc(ev_rx_broadcast), .count(rx_broadcast_count));
    scd_counter #(.W(`SCD_CNT32_W)) u_mcast (.clock(clock), .resetn(resetn),
        .inc(ev_rx_group_addr), .count(rx_group_addr_count));
    scd_counter #(.W(`SCD_CNT16_W)) u_abort (.clock(clock), .resetn(resetn),
        .inc(ev_tx_abort), .count(tx_abort_count));
    scd_counter #(.W(`SCD_CNT16_W)) u_undrn (.clock(clock), .resetn(resetn),
        .inc(ev_tx_underrun_drop), .count(tx_underrun_drop_count));

    // Dump area layout, one 64-bit little-endian word per index.
    wire [63:0] dump_word [`SCD_WORDS];
    assign dump_word[0] = tx_good_count;
    assign dump_word[1] = rx_good_count;
    assign dump_word[2] = tx_fail_count;
    assign dump_word[3] = {align_error_count, fifo_full_drop_count,
        rx_fail_count};
    assign dump_word[4] = {multi_collision_count, single_collision_count};
    assign dump_word[5] = rx_unicast_match_count;
    assign dump_word[6] = rx_broadcast_count;
    assign dump_word[7] = {tx_underrun_drop_count, tx_abort_count,
        rx_group_addr_count};

    wire [63:0] fill_data = dump_word[idx_reg];
    wire fill_push = fill_if.valid && fill_if.ready;
    assign fill_if.valid = (state_reg == SCD_FILL);
    assign fill_if.data = {idx_reg, fill_data};

    scd_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .resetn(resetn),
        .in_if(fill_if),
        .out_if(mem_if)
    );

    assign mem_valid = mem_if.valid;
    assign mem_if.ready = mem_ready;
    assign mem_addr = {base_reg, mem_if.data[FW-1:64], `SCD_BYTE_LSB};
    assign mem_wdata = mem_if.data[63:0];

    // Register decode; the bus never waits.
    wire sel_lo = (paddr == `SCD_DUMP_LO_OFF);
    wire sel_hi = (paddr == `SCD_DUMP_HI_OFF);
    wire mapped = sel_lo || sel_hi;
    wire wr_access = psel && penable && pwrite && mapped;
    wire wr_lo = wr_access && sel_lo;
    wire wr_hi = wr_access && sel_hi;
    wire setup_rd = psel && !penable && !pwrite;
    wire [`SCD_BASE_LSB-1:0] cmd_field =
        (`SCD_BASE_LSB)'(cmd_reg) << `SCD_CMD_BIT;
    wire [31:0] lo_view = {base_reg[31-`SCD_BASE_LSB:0], cmd_field};
    wire [31:0] hi_view = base_reg[`SCD_BASE_W-1:32-`SCD_BASE_LSB];
    wire [31:0] rd_view = sel_lo ? lo_view : (sel_hi ? hi_view : `SCD_ZERO32);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_reg;

    wire dump_done = (state_reg == SCD_DRAIN) && !mem_if.valid;
    // start on command bit, set wins over clear
    wire start_dump = wr_lo && pwdata[`SCD_CMD_BIT] && (!cmd_reg || dump_done);
    wire last_push = fill_push && (idx_reg == `SCD_LAST_IDX);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SCD_IDLE: begin
                if (start_dump) state_next = SCD_FILL;
            end
            SCD_FILL: begin
                if (last_push) state_next = SCD_DRAIN;
            end
            SCD_DRAIN: begin
                if (start_dump) state_next = SCD_FILL;
                else if (dump_done) state_next = SCD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg <= SCD_IDLE;
            idx_reg <= '0;
        end else begin
            state_reg <= state_next;
            if (start_dump) idx_reg <= '0;
            else if (fill_push) idx_reg <= idx_reg + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cmd_reg <= 1'b0;
        end else if (start_dump) begin
            cmd_reg <= 1'b1;
        end else if (dump_done) begin
            cmd_reg <= 1'b0;
        end
    end

    // base held steady while a dump runs
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            base_reg <= `SCD_BASE_RST;
        end else if (wr_lo && (!cmd_reg || dump_done)) begin
            base_reg[31-`SCD_BASE_LSB:0] <= pwdata[31:`SCD_BASE_LSB];
        end else if (wr_hi && (!cmd_reg || dump_done)) begin
            base_reg[`SCD_BASE_W-1:32-`SCD_BASE_LSB] <= pwdata;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            prdata_reg <= `SCD_ZERO32;
        end else if (setup_rd) begin
            prdata_reg <= rd_view;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence s_start;
        start_dump;
    endsequence

    sequence s_filling;
        cmd_reg && (state_reg == SCD_FILL) && (idx_reg == '0);
    endsequence

    sequence s_finish;
        dump_done && !start_dump;
    endsequence

    a_base_address: assert property (
        mem_valid |-> mem_addr[63:`SCD_BASE_LSB] == base_reg
            && mem_addr[2:0] == `SCD_BYTE_LSB)
        else $error("dump address off the programmed base");

    a_cmd_start: assert property (
        s_start |=> s_filling)
        else $error("command bit did not start a dump");

    a_cmd_done: assert property (
        s_finish |=> !cmd_reg ##1 (state_reg == SCD_IDLE || cmd_reg))
        else $error("command bit not cleared after dump");

    a_idle_clear: assert property (
        (state_reg == SCD_IDLE) |-> !cmd_reg)
        else $error("command bit high with engine idle");

    a_word_zero: assert property (
        fill_push && idx_reg == '0 |-> fill_data == tx_good_count)
        else $error("word zero is not the good transmit count");

    a_tx_fail_inc: assert property (
        ev_late_collision |=> tx_fail_count == $past(tx_fail_count) + 64'h1)
        else $error("late collision did not count as failure");

    a_rx_fail_inc: assert property (
        ev_fifo_full_drop |=> rx_fail_count == $past(rx_fail_count) + 32'h1)
        else $error("missed frame not counted as receive error");

    a_align_gate: assert property (
        !mii_mode |=> $stable(align_error_count))
        else $error("alignment count moved outside MII mode");

    a_word_three: assert property (
        fill_push && idx_reg == 3'h3
            |-> fill_data[47:32] == fifo_full_drop_count)
        else $error("drop count not at byte offset 28");

    a_order_eight: assert property (
        last_push |-> fill_data[63:48] == tx_underrun_drop_count
            ##1 state_reg == SCD_DRAIN)
        else $error("last word not followed by drain");

    a_base_frozen: assert property (
        cmd_reg && !dump_done |=> $stable(base_reg))
        else $error("base address changed during a dump");

    a_fill_busy: assert property (
        (state_reg == SCD_FILL) |-> cmd_reg)
        else $error("command bit low while words are filled");

    a_single_col: assert property (
        ev_single_collision |=> single_collision_count
            == $past(single_collision_count) + 32'h1)
        else $error("single collision send not counted");

    a_multi_col: assert property (
        ev_multi_collision |=> multi_collision_count
            == $past(multi_collision_count) + 32'h1)
        else $error("multiple collision send not counted");

    a_word_five: assert property (
        fill_push && idx_reg == 3'h5 |-> fill_data == rx_unicast_match_count)
        else $error("own address count not at byte offset 40");

    a_word_six: assert property (
        fill_push && idx_reg == 3'h6 |-> fill_data == rx_broadcast_count)
        else $error("broadcast count not at byte offset 48");

    a_word_seven: assert property (
        fill_push && idx_reg == 3'h7
            |-> fill_data[31:0] == rx_group_addr_count)
        else $error("multicast count not at byte offset 56");

    a_abort_count: assert property (
        ev_tx_abort |=> tx_abort_count == $past(tx_abort_count) + 16'h1)
        else $error("aborted transmit not counted");
endmodule : scd_top
`default_nettype wire
